// ### core/fhscr_pkg.sv
// Constants, field layouts and carrier types for the floppy host register slice.
// Assumes a 32-bit AHB-Lite bus; each register sits in the low byte of one word.
package fhscr_pkg;
   // Register indices; byte address is four times the index
   localparam logic [3:0] IDX_ALT_STATUS_B = 4'h1;
   localparam logic [3:0] IDX_DIG_OUT = 4'h2;
   localparam logic [3:0] IDX_TAPE = 4'h3;
   localparam logic [3:0] IDX_MAIN_STATUS = 4'h4;
   localparam logic [3:0] IDX_DATA = 4'h5;
   localparam logic [3:0] IDX_DIG_IN = 4'h7;
   localparam logic [3:0] IDX_MODE = 4'h8;
   localparam logic [3:0] IDX_UNMAPPED = 4'hf;
   localparam int unsigned IDX_LSB = 2;
   localparam int unsigned IDX_MSB = 5;
   localparam int unsigned HTRANS_ACTIVE_BIT = 1;
   localparam logic HRESP_OKAY = 1'b0;

   // Compatibility modes held in the mode register
   localparam logic [1:0] MODE_AT = 2'h0;
   localparam logic [1:0] MODE_ALT = 2'h1;
   localparam logic [1:0] MODE_STD = 2'h2;
   localparam int unsigned MODE_SEL_LSB = 0;
   localparam int unsigned MODE_3M_BIT = 2;
   localparam int unsigned MODE_TYPE_LSB = 4;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic [1:0] TYPE_RESET = 2'h0;

   // Digital output register fields
   localparam int unsigned DOR_MOTOR_B = 5;
   localparam int unsigned DOR_MOTOR_A = 4;
   localparam int unsigned DOR_DMA = 3;
   localparam int unsigned DOR_RESET = 2;
   localparam logic [1:0] DOR_HIGH_FIXED = 2'h0;
   localparam logic [1:0] DOR_LOW_FIXED = 2'h3;

   // Status register B fixed fields
   localparam logic [1:0] SRB_STD_HIGH = 2'h3;
   localparam logic SRB_DRV_B_LEVEL = 1'b1;
   localparam logic SRB_DRV_D_C_INV = 1'b0;

   // Tape drive register fields
   localparam logic [1:0] TAPE_HIGH_FIXED = 2'h0;
   localparam logic [1:0] TAPE_NORMAL_ID = 2'h3;
   localparam logic [1:0] TAPE_NORMAL_MID = 2'h3;
   localparam logic [1:0] TAPE_3MODE_MID = 2'h0;
   localparam logic [1:0] TAPE_RESET = 2'h0;

   localparam logic [2:0] MSR_UNITS_FIXED = 3'h0;

   // Controller core status, same clock domain
   typedef struct packed {
      logic host_transfer_request;
      logic transfer_direction;
      logic non_dma_mode;
      logic command_in_progress;
      logic unit0_seeking;
   } fhscr_core_status_type;
endpackage : fhscr_pkg

// ### core/fhscr_top.sv
// Host register slice of the floppy controller behind an AHB-Lite slave port.
// Assumes core strobes and status share hclk; the read-data and drive-present
// pins are asynchronous and are synchronised here.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module fhscr_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire fhscr_pkg::fhscr_core_status_type core_status,
   input wire logic core_write_data_n,
   input wire logic core_write_gate_n,
   input wire logic core_drive_a_sel_n,
   input wire logic read_data_in_n,
   input wire logic second_drive_absent,
   input wire logic [7:0] data_rd_byte,
   output logic data_wr_strobe,
   output logic [7:0] data_wr_byte,
   output logic data_rd_strobe,
   output logic motor_a_out_n,
   output logic motor_b_out_n,
   output logic drive_a_sel_out_n,
   output logic drive_b_sel_out_n,
   output logic drive_c_sel_out_n,
   output logic drive_d_sel_out_n,
   output logic write_data_out_n,
   output logic write_gate_out_n,
   output logic dma_irq_enable,
   output logic controller_reset
);
   import fhscr_pkg::*;

   logic take;
   logic [3:0] addr_idx;
   logic wr_pend;
   logic [3:0] wr_idx;
   logic rd_pend;
   logic [3:0] rd_idx;
   logic rd_fire;
   logic [3:0] rd_sel;
   logic [7:0] rd_val;
   logic wr_fire;

   logic [1:0] mode_sel;
   logic three_mode_en;
   logic [1:0] drive_type_ident;
   logic is_std;
   logic motor_a_on;
   logic motor_b_on;
   logic dma_bit;
   logic run_bit;
   logic [1:0] tape_unit_select;

   logic [2:0] rd_sync;
   logic rd_stable;
   logic rd_rise;
   logic [2:0] absent_sync;
   logic absent_stable;
   logic wd_prev;
   logic wg_prev;
   logic wd_rise;
   logic wg_fall;
   logic flag_clear;
   logic wr_data_edge_flag;
   logic rd_data_edge_flag;
   logic wr_gate_edge_flag;
   logic wd_toggle;
   logic rd_toggle;

   // Address phase decode; anything above the map lands on the unmapped index
   assign take = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
   assign addr_idx = (haddr[31:IDX_MSB+1] == '0 && haddr[1:0] == 2'h0) ?
                     haddr[IDX_MSB:IDX_LSB] : IDX_UNMAPPED;
   assign rd_fire = rd_pend || (take && !hwrite && !wr_pend);
   assign rd_sel = rd_pend ? rd_idx : addr_idx;
   assign wr_fire = wr_pend;
   assign is_std = (mode_sel == MODE_STD);
   assign flag_clear = rd_fire && (rd_sel == IDX_DIG_IN);
   assign rd_rise = (rd_sync[1] == rd_sync[2]) && rd_sync[2] && !rd_stable;
   assign wd_rise = write_data_out_n && !wd_prev;
   assign wg_fall = !write_gate_out_n && wg_prev;

   // Bus handshake; a read right behind a write waits one cycle for the update
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_idx <= IDX_UNMAPPED;
         rd_pend <= 1'b0;
         rd_idx <= IDX_UNMAPPED;
         hreadyout <= 1'b1;
         hresp <= HRESP_OKAY;
      end else begin
         hresp <= HRESP_OKAY;
         wr_pend <= take && hwrite;
         if (take && hwrite) begin
            wr_idx <= addr_idx;
         end
         if (take && !hwrite && wr_pend) begin
            rd_pend <= 1'b1;
            rd_idx <= addr_idx;
            hreadyout <= 1'b0;
         end else begin
            rd_pend <= 1'b0;
            hreadyout <= 1'b1;
         end
      end
   end

   // Read data mux
   always_comb begin
      rd_val = 8'h00;
      unique case (rd_sel)
         IDX_ALT_STATUS_B: begin
            if (is_std) begin
               rd_val = {SRB_STD_HIGH, DOR_LOW_FIXED[0], wd_toggle, rd_toggle,
                         !write_gate_out_n, !motor_b_out_n, !motor_a_out_n};
            end else begin
               rd_val = {absent_stable, SRB_DRV_B_LEVEL, drive_a_sel_out_n,
                         wr_data_edge_flag, rd_data_edge_flag, wr_gate_edge_flag,
                         SRB_DRV_D_C_INV, SRB_DRV_D_C_INV};
            end
         end
         IDX_DIG_OUT: begin
            rd_val = {DOR_HIGH_FIXED, motor_b_on, motor_a_on,
                      dma_bit && !is_std, run_bit, DOR_LOW_FIXED};
         end
         IDX_TAPE: begin
            rd_val = {TAPE_HIGH_FIXED,
                      three_mode_en ? drive_type_ident : TAPE_NORMAL_ID,
                      three_mode_en ? TAPE_3MODE_MID : TAPE_NORMAL_MID,
                      tape_unit_select};
         end
         IDX_MAIN_STATUS: begin
            rd_val = {core_status.host_transfer_request,
                      core_status.transfer_direction,
                      core_status.non_dma_mode,
                      core_status.command_in_progress,
                      MSR_UNITS_FIXED,
                      core_status.unit0_seeking};
         end
         IDX_DATA: begin
            rd_val = data_rd_byte;
         end
         IDX_MODE: begin
            rd_val = {2'h0, drive_type_ident, 1'b0, three_mode_en, mode_sel};
         end
         default: begin
            rd_val = 8'h00;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_fire) begin
         hrdata <= {24'h00_0000, rd_val};
      end
   end

   // Digital output register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         motor_a_on <= 1'b0;
         motor_b_on <= 1'b0;
         dma_bit <= 1'b0;
         run_bit <= 1'b0;
      end else if (wr_fire && wr_idx == IDX_DIG_OUT) begin
         motor_a_on <= hwdata[DOR_MOTOR_A];
         motor_b_on <= hwdata[DOR_MOTOR_B];
         dma_bit <= hwdata[DOR_DMA];
         run_bit <= hwdata[DOR_RESET];
      end
   end

   // Tape select and mode registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tape_unit_select <= TAPE_RESET;
         mode_sel <= MODE_RESET;
         three_mode_en <= 1'b0;
         drive_type_ident <= TYPE_RESET;
      end else if (wr_fire) begin
         if (wr_idx == IDX_TAPE) begin
            tape_unit_select <= hwdata[1:0];
         end
         if (wr_idx == IDX_MODE) begin
            mode_sel <= hwdata[MODE_SEL_LSB +: 2];
            three_mode_en <= hwdata[MODE_3M_BIT];
            drive_type_ident <= hwdata[MODE_TYPE_LSB +: 2];
         end
      end
   end

   // Data register strobes toward the controller core
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_wr_strobe <= 1'b0;
         data_wr_byte <= 8'h00;
         data_rd_strobe <= 1'b0;
      end else begin
         data_wr_strobe <= wr_fire && wr_idx == IDX_DATA;
         if (wr_fire && wr_idx == IDX_DATA) begin
            data_wr_byte <= hwdata[7:0];
         end
         data_rd_strobe <= rd_fire && rd_sel == IDX_DATA;
      end
   end

   // Drive-side pins and control outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         motor_a_out_n <= 1'b1;
         motor_b_out_n <= 1'b1;
         drive_a_sel_out_n <= 1'b1;
         drive_b_sel_out_n <= 1'b1;
         drive_c_sel_out_n <= 1'b1;
         drive_d_sel_out_n <= 1'b1;
         write_data_out_n <= 1'b1;
         write_gate_out_n <= 1'b1;
         dma_irq_enable <= 1'b0;
         controller_reset <= 1'b1;
      end else begin
         motor_a_out_n <= !motor_a_on;
         motor_b_out_n <= 1'b1;
         drive_a_sel_out_n <= core_drive_a_sel_n;
         drive_b_sel_out_n <= 1'b1;
         drive_c_sel_out_n <= 1'b1;
         drive_d_sel_out_n <= 1'b1;
         write_data_out_n <= core_write_data_n;
         write_gate_out_n <= core_write_gate_n;
         dma_irq_enable <= is_std ? 1'b1 : dma_bit;
         controller_reset <= !run_bit;
      end
   end

   // Pin synchronisers; a change counts once the last two stages agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_sync <= 3'h7;
         rd_stable <= 1'b1;
         absent_sync <= 3'h7;
         absent_stable <= 1'b1;
      end else begin
         rd_sync <= {rd_sync[1:0], read_data_in_n};
         if (rd_sync[1] == rd_sync[2]) begin
            rd_stable <= rd_sync[2];
         end
         absent_sync <= {absent_sync[1:0], second_drive_absent};
         if (absent_sync[1] == absent_sync[2]) begin
            absent_stable <= absent_sync[2];
         end
      end
   end

   // Edge-latched flags; a new edge wins over the clearing read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wd_prev <= 1'b1;
         wg_prev <= 1'b1;
         wr_data_edge_flag <= 1'b0;
         rd_data_edge_flag <= 1'b0;
         wr_gate_edge_flag <= 1'b0;
         wd_toggle <= 1'b0;
         rd_toggle <= 1'b0;
      end else begin
         wd_prev <= write_data_out_n;
         wg_prev <= write_gate_out_n;
         wr_data_edge_flag <= wd_rise || (wr_data_edge_flag && !flag_clear);
         rd_data_edge_flag <= rd_rise || (rd_data_edge_flag && !flag_clear);
         wr_gate_edge_flag <= wg_fall || (wr_gate_edge_flag && !flag_clear);
         wd_toggle <= wd_toggle ^ wd_rise;
         rd_toggle <= rd_toggle ^ rd_rise;
      end
   end
endmodule : fhscr_top

// ### testbench/fhscr_chk.sv
// Port checker for the floppy host register slice.
// Bound into fhscr_top; hready is the slave's own hreadyout.
`timescale 1ns/1ps
module fhscr_chk
   import fhscr_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic data_wr_strobe,
   input wire logic [7:0] data_wr_byte,
   input wire logic motor_a_out_n,
   input wire logic motor_b_out_n,
   input wire logic drive_b_sel_out_n,
   input wire logic dma_irq_enable,
   input wire logic controller_reset
);
   logic dp;
   logic dp_wr;
   logic [3:0] dp_idx;
   logic [1:0] mode_q;
   logic dor_wr;
   logic rd_done;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Data phase tracking of the one slave
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp <= 1'b0;
         dp_wr <= 1'b0;
         dp_idx <= 4'h0;
      end else if (hready) begin
         dp <= hsel && htrans[HTRANS_ACTIVE_BIT] && (haddr[31:6] == 26'h0);
         dp_wr <= hwrite;
         dp_idx <= haddr[5:2];
      end
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q <= MODE_RESET;
      end else if (dp && dp_wr && hready && dp_idx == IDX_MODE) begin
         mode_q <= hwdata[1:0];
      end
   end
   assign dor_wr = dp && dp_wr && hready && dp_idx == IDX_DIG_OUT;
   assign rd_done = dp && !dp_wr && hreadyout;
   AST_OKAY: assert property (hresp == HRESP_OKAY) else $error("hresp not okay");
   AST_WAIT_ONE: assert property (!hreadyout |=> hreadyout) else $error("long wait");
   AST_MOTOR_A: assert property (dor_wr |-> ##2 motor_a_out_n == !$past(hwdata[DOR_MOTOR_A], 2))
      else $error("motor a pin wrong");
   AST_CTRL_RST: assert property (dor_wr |-> ##2 controller_reset == !$past(hwdata[DOR_RESET], 2))
      else $error("controller reset wrong");
   AST_DMA_WR: assert property (dor_wr && mode_q != MODE_STD
      |-> ##2 dma_irq_enable == $past(hwdata[DOR_DMA], 2)) else $error("dma enable wrong");
   AST_DMA_STD: assert property (mode_q == MODE_STD && $past(mode_q, 2) == MODE_STD
      |-> dma_irq_enable) else $error("dma off in standard mode");
   AST_PINS_IDLE: assert property (motor_b_out_n && drive_b_sel_out_n)
      else $error("unsupported pin active");
   AST_DOR_FIXED: assert property (rd_done && dp_idx == IDX_DIG_OUT
      |-> hrdata[7:6] == DOR_HIGH_FIXED && hrdata[1:0] == DOR_LOW_FIXED)
      else $error("output reg fixed bits");
   AST_TAPE_FIXED: assert property (rd_done && dp_idx == IDX_TAPE
      |-> hrdata[7:6] == TAPE_HIGH_FIXED) else $error("tape high bits");
   AST_MSR_FIXED: assert property (rd_done && dp_idx == IDX_MAIN_STATUS
      |-> hrdata[3:1] == MSR_UNITS_FIXED && hrdata[31:8] == 24'h0)
      else $error("status unit bits");
   AST_DATA_WR: assert property (dp && dp_wr && hready && dp_idx == IDX_DATA
      |=> data_wr_strobe && data_wr_byte == $past(hwdata[7:0])) else $error("data write");
   COV_DOR_WR: cover property (dor_wr);
   COV_WAIT: cover property (!hreadyout);
   COV_TAPE_RD: cover property (rd_done && dp_idx == IDX_TAPE);
endmodule : fhscr_chk

bind fhscr_top fhscr_chk i_chk (.*);

// ### testbench/fhscr_core_model.sv
// Behavioural core and drive side feeding the register slice.
// Strobes share hclk; the read-data pin moves off the clock edge.
`timescale 1ns/1ps
module fhscr_core_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [2:0] kick,
   input wire logic data_rd_strobe,
   output logic core_write_data_n,
   output logic core_write_gate_n,
   output logic read_data_in_n,
   output logic [7:0] data_rd_byte
);
   // Lines go low while kicked; release gives the rising edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core_write_data_n <= 1'b1;
         core_write_gate_n <= 1'b1;
         data_rd_byte <= 8'h5a;
      end else begin
         core_write_data_n <= !kick[0];
         core_write_gate_n <= !kick[2];
         if (data_rd_strobe) begin
            data_rd_byte <= data_rd_byte + 8'h01;
         end
      end
   end
   initial read_data_in_n = 1'b1;
   always @(kick[1]) begin
      read_data_in_n <= #3 !kick[1];
   end
endmodule : fhscr_core_model

// ### testbench/tb_top.sv
// Register-access tests for the floppy host register slice.
// The bench is the only AHB-Lite master; hready follows hreadyout.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_top;
   import fhscr_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic hreadyout, hresp, hready;
   fhscr_core_status_type core_status = '0;
   logic core_write_data_n, core_write_gate_n, read_data_in_n;
   logic core_drive_a_sel_n = 1'b1, second_drive_absent = 1'b1;
   logic [7:0] data_rd_byte, data_wr_byte;
   logic data_wr_strobe, data_rd_strobe, motor_a_out_n, motor_b_out_n;
   logic drive_a_sel_out_n, drive_b_sel_out_n, drive_c_sel_out_n, drive_d_sel_out_n;
   logic write_data_out_n, write_gate_out_n, dma_irq_enable, controller_reset;
   logic [2:0] kick = 3'h0;
   logic [4:0] st;
   int err_total = 0, n_checks = 0;
   assign hready = hreadyout;
   fhscr_top i_fhscr_top (.*);
   fhscr_core_model i_fhscr_core_model (.*);
   initial forever #5 hclk = ~hclk;
   task automatic close_out;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out
   task automatic wait_rdy;
      do @(posedge hclk); while (hready !== 1'b1);
   endtask : wait_rdy
   task automatic addr_ph(input logic [3:0] idx, input logic wr);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {26'h0, idx, 2'h0};
   endtask : addr_ph
   task automatic idle;
      hsel <= 1'b0;
      htrans <= 2'h0;
   endtask : idle
   task automatic bus_wr(input logic [3:0] idx, input logic [7:0] d);
      addr_ph(idx, 1'b1);
      wait_rdy();
      idle();
      hwdata <= {24'h0, d};
      wait_rdy();
   endtask : bus_wr
   task automatic bus_rd(input logic [3:0] idx, output logic [31:0] d);
      addr_ph(idx, 1'b0);
      wait_rdy();
      idle();
      wait_rdy();
      d = hrdata;
   endtask : bus_rd
   // Write then read in its data phase: the slave inserts a wait
   task automatic wr_rd(input logic [3:0] idx, input logic [7:0] w, output logic [31:0] d);
      addr_ph(idx, 1'b1);
      wait_rdy();
      hwdata <= {24'h0, w};
      addr_ph(idx, 1'b0);
      wait_rdy();
      idle();
      wait_rdy();
      d = hrdata;
   endtask : wr_rd
   task automatic rd_chk(input string nm, input logic [3:0] idx, input logic [31:0] e);
      logic [31:0] d;
      bus_rd(idx, d);
      `CHK(nm, e, d)
   endtask : rd_chk
   initial begin
      #100us;
      err_total++;
      close_out();
   end
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      `CHK("motor_a", 1'b1, motor_a_out_n)
      `CHK("ctl_rst", 1'b1, controller_reset)
      `CHK("drv_b", 1'b1, drive_b_sel_out_n)
      `CHK("drv_c", 1'b1, drive_c_sel_out_n)
      `CHK("drv_d", 1'b1, drive_d_sel_out_n)
      `CHK("wr_data", 1'b1, write_data_out_n)
      `CHK("hresp", HRESP_OKAY, hresp)
      rd_chk("dor", IDX_DIG_OUT, 32'h03);
      rd_chk("tape", IDX_TAPE, 32'h3c);
      rd_chk("srb", IDX_ALT_STATUS_B, 32'he0);
      rd_chk("msr", IDX_MAIN_STATUS, 32'h0);
      wr_rd(IDX_DIG_OUT, 8'hff, rd);
      `CHK("dor_rb", 32'h3f, rd)
      `CHK("motor_a", 1'b0, motor_a_out_n)
      `CHK("dma", 1'b1, dma_irq_enable)
      `CHK("ctl_rst", 1'b0, controller_reset)
      bus_wr(IDX_DIG_OUT, 8'h00);
      repeat (2) @(posedge hclk);
      `CHK("dma", 1'b0, dma_irq_enable)
      `CHK("ctl_rst", 1'b1, controller_reset)
      bus_wr(IDX_DIG_OUT, 8'h04);
      bus_wr(IDX_TAPE, 8'hff);
      rd_chk("tape", IDX_TAPE, 32'h3f);
      bus_wr(IDX_MODE, 8'h24);
      rd_chk("tape_3m", IDX_TAPE, 32'h23);
      for (int i = 0; i < 5; i++) begin
         st = 5'h1 << i;
         core_status <= st;
         rd_chk("msr", IDX_MAIN_STATUS, {24'h0, st[4:1], 3'h0, st[0]});
      end
      second_drive_absent <= 1'b0;
      bus_wr(IDX_MODE, {6'h0, MODE_ALT});
      kick <= 3'h7;
      repeat (4) @(posedge hclk);
      kick <= 3'h0;
      repeat (8) @(posedge hclk);
      rd_chk("srb_flags", IDX_ALT_STATUS_B, 32'h7c);
      rd_chk("din", IDX_DIG_IN, 32'h0);
      core_drive_a_sel_n <= 1'b0;
      // Select pin is registered; let it reach the pin before the read
      @(posedge hclk);
      rd_chk("srb_clr", IDX_ALT_STATUS_B, 32'h40);
      bus_wr(IDX_MODE, {6'h0, MODE_STD});
      bus_wr(IDX_DIG_OUT, 8'h1c);
      rd_chk("dor_std", IDX_DIG_OUT, 32'h17);
      bus_wr(IDX_DIG_OUT, 8'h14);
      repeat (2) @(posedge hclk);
      `CHK("dma_std", 1'b1, dma_irq_enable)
      bus_rd(IDX_ALT_STATUS_B, rd);
      `CHK("srb_std", 32'he1, rd & 32'he1)
      bus_wr(IDX_DATA, 8'ha5);
      @(posedge hclk);
      `CHK("wr_byte", 8'ha5, data_wr_byte)
      rd_chk("data", IDX_DATA, 32'h5a);
      repeat (3) @(posedge hclk);
      `CHK("rd_next", 8'h5b, data_rd_byte)
      bus_wr(IDX_UNMAPPED, 8'hff);
      rd_chk("unmapped", IDX_UNMAPPED, 32'h0);
      close_out();
   end
endmodule : tb_top
